// ==== core/wesps_top.sv ====
`timescale 1ns/1ns
// Functional notes
// - Magic packet sets bit 1 of wake control/status; write one clears it.
// - Link change event sets bit 0 of wake control/status; write one clears it.
// - Only power-up reset clears both flags; hardware and software resets keep them.
// - Pattern masks, CRCs and offsets are written through the one pattern data port; enables sit in wake control/status.
// - Each pattern mask is 128 bits in four words, low word first.
// - Fifth word: CRC-16 in 31:16, 15:8 reserved, start offset in 7:0.
// - Pattern n occupies five words from word 5*(n-1); five patterns total.
// - Seed select picks CRC-16 start value 0000h or FFFFh.
// - Link up/down detect enables choose which link transitions set link flag.
// - Enabled magic or link events raise the wake event status bit.
// - One enable bit per pattern gates whether its match counts.
module wesps_top import wesps_pkg::*; (
  // Clock and power-up reset
  input logic clk,
  input logic rstn,
  // Hardware and software resets, synchronous, active high
  input logic chip_reset,
  input logic soft_reset,
  // Events from the receive path and the PHY
  input logic magic_frame_rx,
  input logic link_status,
  // Pattern readout toward the matching engine
  input logic [2:0] pat_sel,
  output wesps_pat_t pat_q,
  output logic [15:0] crc_seed,
  // Wake and interrupt
  output logic wake_event_status,
  output logic irq,
  // AXI4-Lite slave
  input logic [AW-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [AW-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [AW-1:0] a);
    is_mapped = (a == A_WCS) || (a == A_PDP) || (a == A_IST) || (a == A_IMSK) ||
                (a == A_PTR);
  endfunction

  function automatic logic [PW-1:0] step_ptr(input logic [PW-1:0] p);
    step_ptr = (p == PTR_LAST) ? '0 : p + 5'd1;
  endfunction

  function automatic logic is_crc(input logic [PW-1:0] p);
    is_crc = (32'(p) % WPP) == (WPP - 1);
  endfunction

  function automatic logic [PW-1:0] pat_base(input logic [2:0] s);
    pat_base = PW'(32'(s) * WPP);
  endfunction

  // ----------------------------------------------------------------
  // AXI write channel
  // ----------------------------------------------------------------
  logic aw_held, w_held, wr_fire, loc_rst;
  logic [AW-1:0] awa;
  logic [31:0] wd, wm;
  logic [3:0] wstrb_q;

  assign awready = !aw_held;
  assign wready = !w_held;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign loc_rst = chip_reset || soft_reset;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wm[8*i +: 8] = {8{w_held && wstrb_q[i]}};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awa <= '0;
      wd <= '0;
      wstrb_q <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        awa <= awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wd <= wdata;
        wstrb_q <= wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OK;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= is_mapped(awa) ? RESP_OK : RESP_DEC;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------
  logic [31:0] ctl;
  logic [NIRQ-1:0] ist, imsk;
  logic flg_lnk, flg_mag, link_prev, link_seen, lnk_evt, wak_evt;
  logic wcs_wr, ist_wr;

  assign wcs_wr = wr_fire && (awa == A_WCS);
  assign ist_wr = wr_fire && (awa == A_IST);
  // A link already up at power-up is not a change, so the first sample only primes
  assign lnk_evt = link_seen && ((link_status && !link_prev && ctl[B_LUP]) ||
                                 (!link_status && link_prev && ctl[B_LDN]));
  assign wak_evt = (magic_frame_rx && ctl[B_MWE]) || (lnk_evt && ctl[B_LWE]);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl <= '0;
    end else if (loc_rst) begin
      ctl <= '0;
    end else if (wcs_wr) begin
      ctl <= (ctl & ~(wm & CTL_RW)) | (wd & wm & CTL_RW);
    end
  end

  // Mask ignores hardware and software resets, so a write beside one is not lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      imsk <= '0;
    end else if (wr_fire && (awa == A_IMSK)) begin
      imsk <= (imsk & ~wm[NIRQ-1:0]) | (wd[NIRQ-1:0] & wm[NIRQ-1:0]);
    end
  end

  // Sticky flags see power-up reset only; set wins over a same-cycle clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flg_lnk <= 1'b0;
      flg_mag <= 1'b0;
    end else begin
      flg_mag <= magic_frame_rx || (flg_mag && !(wcs_wr && wd[B_MAG] && wm[B_MAG]));
      flg_lnk <= lnk_evt || (flg_lnk && !(wcs_wr && wd[B_LNK] && wm[B_LNK]));
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_prev <= 1'b0;
      link_seen <= 1'b0;
    end else begin
      link_prev <= link_status;
      link_seen <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ist <= '0;
    end else begin
      ist <= (ist & ~(ist_wr ? (wd[NIRQ-1:0] & wm[NIRQ-1:0]) : '0)) |
             {wak_evt, magic_frame_rx, lnk_evt};
    end
  end

  assign wake_event_status = ist[I_WAK];
  assign irq = |(ist & imsk);

  // ----------------------------------------------------------------
  // Pattern store behind the data port
  // ----------------------------------------------------------------
  logic [31:0] store [NWORD];
  logic [PW-1:0] ptr;
  logic pdp_wr, pdp_rd, ar_fire;

  assign ar_fire = arvalid && arready;
  assign pdp_wr = wr_fire && (awa == A_PDP);
  assign pdp_rd = ar_fire && (araddr == A_PDP);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr <= '0;
    end else if (loc_rst) begin
      ptr <= '0;
    end else if (pdp_wr || pdp_rd) begin
      ptr <= step_ptr(ptr);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NWORD; i++) begin
        store[i] <= '0;
      end
    end else if (pdp_wr) begin
      store[ptr] <= (store[ptr] & ~wm) | (wd & wm);
    end
  end

  // Readout is registered: the matcher sees a new selection one cycle later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pat_q <= '0;
      crc_seed <= SEED_ZERO;
    end else begin
      crc_seed <= ctl[B_SEED] ? SEED_ONES : SEED_ZERO;
      pat_q <= '0;
      if (32'(pat_sel) < NPAT) begin
        pat_q.mask <= {store[pat_base(pat_sel) + 5'd3], store[pat_base(pat_sel) + 5'd2],
                       store[pat_base(pat_sel) + 5'd1], store[pat_base(pat_sel)]};
        pat_q.crc <= store[pat_base(pat_sel) + 5'd4][31:CRC_LO];
        pat_q.offset <= store[pat_base(pat_sel) + 5'd4][OFS_W-1:0];
        pat_q.enable <= ctl[B_PE1 - 32'(pat_sel)];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_word;

  // Read never shares a cycle with a write, so the pointer steps once per access
  assign arready = !rvalid && !wr_fire;

  always_comb begin
    rd_word = '0;
    case (araddr)
      A_WCS: begin
        rd_word = ctl & CTL_RW;
        rd_word[B_MAG] = flg_mag;
        rd_word[B_LNK] = flg_lnk;
      end
      A_PDP: rd_word = is_crc(ptr) ? (store[ptr] & CRCW_RD_MASK) : store[ptr];
      A_IST: rd_word[NIRQ-1:0] = ist;
      A_IMSK: rd_word[NIRQ-1:0] = imsk;
      A_PTR: rd_word[PW-1:0] = ptr;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OK;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= is_mapped(araddr) ? RESP_OK : RESP_DEC;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_mag_clear;
    wcs_wr && wd[B_MAG] && wm[B_MAG] && !magic_frame_rx;
  endsequence

  sequence s_pdp_access;
    (pdp_wr || pdp_rd) && !loc_rst;
  endsequence

  a_magic_flag_set: assert property (magic_frame_rx |=> flg_mag)
    else $error("magic flag not set");
  a_magic_flag_clear: assert property (s_mag_clear |=> !flg_mag)
    else $error("magic flag not cleared");
  a_link_flag_up: assert property (
    link_seen && !link_prev && link_status && ctl[B_LUP] |=> flg_lnk)
    else $error("link up not flagged");
  a_link_flag_hold: assert property ($fell(flg_lnk) |-> $past(wcs_wr && wd[B_LNK]))
    else $error("link flag lost without write");
  a_magic_survives_reset: assert property (flg_mag && loc_rst |=> flg_mag)
    else $error("magic flag lost on soft reset");
  a_ptr_step: assert property (s_pdp_access |=> ptr == step_ptr($past(ptr)))
    else $error("pointer did not step");
  a_ptr_wrap: assert property (s_pdp_access ##0 ptr == PTR_LAST |=> ptr == '0)
    else $error("pointer did not wrap");
  a_wake_magic: assert property (magic_frame_rx && ctl[B_MWE] |=> wake_event_status)
    else $error("wake status missing");
  a_seed_value: assert property (
    ##1 crc_seed == ($past(ctl[B_SEED]) ? SEED_ONES : SEED_ZERO))
    else $error("crc seed wrong");
  a_mask_low_word: assert property (
    32'(pat_sel) < NPAT |=> pat_q.mask[31:0] == $past(store[pat_base(pat_sel)]))
    else $error("mask word order wrong");
  a_pat_enable: assert property (pat_sel == 3'd0 |=> pat_q.enable == $past(ctl[B_PE1]))
    else $error("pattern enable wrong");
endmodule

// ==== core/wesps_pkg.sv ====
package wesps_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int AW = 8;
  localparam logic [AW-1:0] A_WCS = 8'h68;
  localparam logic [AW-1:0] A_PDP = 8'h70;
  localparam logic [AW-1:0] A_IST = 8'h80;
  localparam logic [AW-1:0] A_IMSK = 8'h84;
  localparam logic [AW-1:0] A_PTR = 8'h88;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_DEC = 2'b11;
  // ----------------------------------------------------------------
  // Wake control/status fields
  // ----------------------------------------------------------------
  localparam int B_LNK = 0;
  localparam int B_MAG = 1;
  localparam int B_LWE = 8;
  localparam int B_MWE = 9;
  localparam int B_LUP = 16;
  localparam int B_LDN = 17;
  localparam int B_PE1 = 29;
  localparam int B_SEED = 30;
  localparam logic [31:0] CTL_RW = 32'h7E03_0700;
  localparam logic [15:0] SEED_ZERO = 16'h0000;
  localparam logic [15:0] SEED_ONES = 16'hFFFF;
  // ----------------------------------------------------------------
  // Pattern store layout
  // ----------------------------------------------------------------
  localparam int NPAT = 5;
  localparam int WPP = 5;
  localparam int NWORD = NPAT * WPP;
  localparam int PW = 5;
  localparam logic [PW-1:0] PTR_LAST = 5'd24;
  localparam int CRC_LO = 16;
  localparam int OFS_W = 8;
  localparam logic [31:0] CRCW_RD_MASK = 32'hFFFF_00FF;
  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int I_LNK = 0;
  localparam int I_MAG = 1;
  localparam int I_WAK = 2;
  localparam int NIRQ = 3;

  typedef struct packed {
    logic [127:0] mask;
    logic [15:0] crc;
    logic [7:0] offset;
    logic enable;
  } wesps_pat_t;
endpackage

// ==== testbench/wesps_evt_src.sv ====
`timescale 1ns/1ns
module wesps_evt_src (
  // Clock
  input wire logic clk,
  // Event lines toward the block
  output logic magic_frame_rx,
  output logic link_status
);
  initial begin
    magic_frame_rx = 1'b0;
    link_status = 1'b0;
  end
  // One-cycle pulse per received magic packet
  task automatic send_magic();
    @(posedge clk);
    magic_frame_rx <= 1'b1;
    @(posedge clk);
    magic_frame_rx <= 1'b0;
  endtask
  // Link level is held until the next change, as a PHY would
  task automatic set_link(input logic up);
    @(posedge clk);
    link_status <= up;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top import wesps_pkg::*;;
  logic clk, rstn, chip_reset, soft_reset, magic_frame_rx, link_status;
  logic [2:0] pat_sel;
  wesps_pat_t pat_q, pe;
  logic [15:0] crc_seed;
  logic wake_event_status, irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, en;
  logic [31:0] mem [NWORD];
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [33:0] exp_q [$];
  logic [33:0] note;
  int num_errors, tests_run, cycles;

  wesps_top dut (.clk, .rstn, .chip_reset, .soft_reset, .magic_frame_rx, .link_status,
    .pat_sel, .pat_q, .crc_seed, .wake_event_status, .irq, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  wesps_evt_src src (.clk(clk), .magic_frame_rx(magic_frame_rx), .link_status(link_status));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [152:0] seen, input logic [152:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // ----------------------------------------------------------------
  // Bus master: each channel released at the edge it is taken
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0000_0000});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    exp_q.push_back({r, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
    end while (arvalid || rready);
  endtask

  // Answers are matched in order against the oldest note
  always @(posedge clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      note = exp_q.pop_front();
      chk("bus answer", bvalid ? {bresp, 32'h0000_0000} : {rresp, rdata}, note);
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    chip_reset = 1'b0;
    soft_reset = 1'b0;
    pat_sel = 3'd0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    seed = 32'h0000_9ffd;
    {num_errors, tests_run, cycles} = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("crc_seed", crc_seed, SEED_ZERO);
    rd(A_WCS, 32'h0000_0000, RESP_OK);
    rd(8'h7C, 32'h0000_0000, RESP_DEC);
    wr(8'h69, 32'hFFFF_FFFF, RESP_DEC);
    wr(A_IMSK, 32'h0000_0007, RESP_OK);
    wr(A_WCS, 32'h7E03_0300, RESP_OK);
    rd(A_WCS, 32'h7E03_0300, RESP_OK);
    chk("crc_seed", crc_seed, SEED_ONES);
    src.send_magic();
    rd(A_WCS, 32'h7E03_0302, RESP_OK);
    chk("wake", wake_event_status, 1'b1);
    chk("irq", irq, 1'b1);
    wr(A_WCS, 32'h7E03_0302, RESP_OK);
    rd(A_WCS, 32'h7E03_0300, RESP_OK);
    wr(A_IST, 32'h0000_0007, RESP_OK);
    chk("irq", irq, 1'b0);
    // Up and down with the matching detect enable, then with the other one
    for (int i = 0; i < 4; i++) begin
      en = (i == 0 || i == 3) ? 32'h0001_0100 : 32'h0002_0100;
      wr(A_WCS, en, RESP_OK);
      src.set_link(i % 2 == 0);
      repeat (3) @(posedge clk);
      rd(A_WCS, en | ((i < 2) ? 32'h1 : 32'h0), RESP_OK);
      wr(A_WCS, en | 32'h1, RESP_OK);
    end
    chk("wake", wake_event_status, 1'b1);
    chk("irq", irq, 1'b1);
    wr(A_IMSK, 32'h0000_0000, RESP_OK);
    chk("irq", irq, 1'b0);
    src.send_magic();
    chip_reset <= 1'b1;
    @(posedge clk);
    chip_reset <= 1'b0;
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    rd(A_WCS, 32'h0000_0002, RESP_OK);
    wr(A_WCS, 32'h2800_0000, RESP_OK);
    rd(A_PTR, 32'h0000_0000, RESP_OK);
    for (int k = 0; k < NWORD; k++) begin
      mem[k] = rnd();
      wr(A_PDP, mem[k], RESP_OK);
    end
    rd(A_PTR, 32'h0000_0000, RESP_OK);
    for (int k = 0; k < NWORD; k++) begin
      rd(A_PDP, (k % WPP == 4) ? (mem[k] & CRCW_RD_MASK) : mem[k], RESP_OK);
    end
    for (int p = 0; p < 8; p++) begin
      pat_sel <= p[2:0];
      repeat (2) @(posedge clk);
      pe = '0;
      if (p < NPAT) begin
        pe.mask = {mem[5*p+3], mem[5*p+2], mem[5*p+1], mem[5*p]};
        pe.crc = mem[5*p+4][31:CRC_LO];
        pe.offset = mem[5*p+4][OFS_W-1:0];
        pe.enable = (p == 0 || p == 2);
      end
      chk("pat_q", pat_q, pe);
    end
    // Byte lanes: only the strobed byte of the control word is written
    wstrb <= 4'h2;
    wr(A_WCS, 32'hFFFF_FFFF, RESP_OK);
    rd(A_WCS, 32'h2800_0702, RESP_OK);
    wstrb <= 4'h1;
    wr(A_WCS, 32'hFFFF_FFFF, RESP_OK);
    rd(A_WCS, 32'h2800_0700, RESP_OK);
    wstrb <= 4'hF;
    // Power-up reset in mid-run clears the control word
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(A_WCS, 32'h0000_0000, RESP_OK);
    wrap_up();
  end
endmodule
